// ### rtl/fdc_glue.sv
// floppy interface glue: ports, nmi, drive latch, wait, clocks, precomp
`timescale 1ns/10ps
module fdc_glue import fdc_glue_pkg::*; #(
    parameter int MOTOR_CYCLES = MOTOR_ON_CYCLES,
    parameter int WATCHDOG_W = WATCHDOG_WIDTH
) (
    input wire logic clk, // 20 MHz system clock
    input wire logic arst_n, // async reset, low
    input wire logic io_write, // port write pulse
    input wire logic io_read, // port read pulse
    input wire logic [7:0] port_addr, // port address
    input wire logic [7:0] port_wdata, // port write data
    output logic [7:0] port_rdata, // port read data
    input wire logic [7:0] core_rdata, // core register read data
    output logic core_write_strobe, // core register write pulse
    output logic core_read_strobe, // core register read pulse
    output logic [1:0] core_reg_index, // core register index
    input wire logic core_irq, // core interrupt request
    input wire logic core_data_request, // core data request
    input wire logic core_write_pulse, // core write pulse
    input wire logic core_early, // write pulse flagged early
    input wire logic core_late, // write pulse flagged late
    output logic write_pulse_ready, // buffer can take a pulse
    input wire logic disk_read_select_n, // disk read select, low
    input wire logic serial_read_select_n, // serial read select, low
    output logic bus_drive_to_cpu, // transceiver drives cpu bus
    output logic [3:0] drive_select, // drive selects 0-3
    output logic side_select, // head side
    output logic motor_on, // spindle motor on
    output logic double_density_enable, // mfm mode
    output logic double_density_enable_n, // fm mode
    output logic cpu_wait_n, // processor wait, low
    output logic cpu_nmi_n, // processor nmi, low
    output logic write_data_out, // shaped write data
    output logic precomp_parallel_load, // precomp load pulse
    output logic clk_2mhz, // 2 MHz clock
    output logic clk_1mhz, // 1 MHz clock
    output logic separator_reference_clock, // 4 MHz reference
    output logic separator_divisor_sel0, // divisor select 0
    output logic separator_divisor_sel1 // divisor select 1
);
    localparam int MOTOR_W = $clog2(MOTOR_CYCLES + 1);
    localparam logic [2:0] DIV_LAST = 3'(DIV_4M - 1);
    localparam logic [2:0] DIV_HALF = 3'(DIV_4M / 2);
    localparam logic [3:0] STRETCH_LOAD = 4'(STRETCH_CYCLES - 1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [2:0] div_count;
    logic tick_4m;
    logic tick_1m;
    logic nmi_mask_write;
    logic latch_write;
    logic status_read;
    logic core_hit;
    logic [1:0] nmi_mask;
    logic precomp_enable;
    logic precomp_active;
    logic wait_held;
    logic wait_hold_req;
    logic [WATCHDOG_W-1:0] watchdog_count;
    logic wait_watchdog_expiry;
    logic wait_short_release;
    logic wait_release;
    logic [MOTOR_W-1:0] motor_count;
    logic motor_end;
    logic motor_timeout;
    logic reset_flag;
    logic pulse_prev;
    logic pulse_pending;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic [1:0] fifo_out_data;
    logic fifo_pop;
    logic [2:0] shift_reg;
    logic fire;
    logic [3:0] stretch_count;

    // 4 MHz enable from the 20 MHz clock; 4 MHz itself is uneven (2 of 5)
    assign tick_4m = div_count == DIV_LAST;
    // 1 MHz steps on the falling half of 2 MHz, hence the lag
    assign tick_1m = tick_4m && clk_2mhz && !clk_1mhz;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= 3'h0;
            separator_reference_clock <= 1'b0;
        end else begin
            div_count <= tick_4m ? 3'h0 : div_count + 3'h1;
            separator_reference_clock <= div_count < DIV_HALF;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_2mhz <= 1'b0;
            clk_1mhz <= 1'b0;
        end else if (tick_4m) begin
            clk_2mhz <= ~clk_2mhz;
            if (clk_2mhz) clk_1mhz <= ~clk_1mhz;
        end
    end

    // port decode
    assign nmi_mask_write = io_write && port_addr == PORT_NMI;
    assign latch_write = io_write && port_addr == PORT_DRIVE;
    assign status_read = io_read && port_addr == PORT_NMI;
    assign core_hit = port_addr[7:2] == PORT_CORE_CMD[7:2];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_write_strobe <= 1'b0;
            core_read_strobe <= 1'b0;
            core_reg_index <= 2'h0;
        end else begin
            core_write_strobe <= io_write && core_hit;
            core_read_strobe <= io_read && core_hit;
            if ((io_write || io_read) && core_hit) core_reg_index <= port_addr[1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_rdata <= READ_UNMAPPED;
        end else if (status_read) begin
            port_rdata <= {~core_irq, ~motor_timeout, ~reset_flag, STATUS_RESERVED};
        end else if (io_read) begin
            port_rdata <= core_hit ? core_rdata : READ_UNMAPPED;
        end
    end

    // reset shows in status until software reads it once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_flag <= 1'b1;
        end else if (status_read) begin
            reset_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_mask <= 2'h0;
        end else if (nmi_mask_write) begin
            nmi_mask <= {port_wdata[MASK_CORE_BIT], port_wdata[MASK_MOTOR_BIT]};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_nmi_n <= 1'b1;
        end else begin
            cpu_nmi_n <= ~((core_irq && nmi_mask[1]) || (motor_timeout && nmi_mask[0]));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_drive_to_cpu <= 1'b0;
        end else begin
            bus_drive_to_cpu <= !(disk_read_select_n && serial_read_select_n);
        end
    end

    // motor one-shot; a write reloads it, so it never expires under a write
    assign motor_end = motor_on && motor_count == MOTOR_W'(1) && !latch_write;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_count <= '0;
            motor_on <= 1'b0;
        end else if (latch_write) begin
            motor_count <= MOTOR_W'(MOTOR_CYCLES);
            motor_on <= 1'b1;
        end else if (motor_end) begin
            motor_count <= '0;
            motor_on <= 1'b0;
        end else if (motor_count != '0) begin
            motor_count <= motor_count - MOTOR_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_timeout <= 1'b0;
        end else if (motor_end) begin
            motor_timeout <= 1'b1;
        end else if (latch_write) begin
            motor_timeout <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_select <= 4'h0;
            side_select <= 1'b0;
            double_density_enable <= 1'b0;
            double_density_enable_n <= 1'b1;
            separator_divisor_sel0 <= 1'b1;
            separator_divisor_sel1 <= 1'b0;
        end else if (latch_write) begin
            drive_select <= port_wdata[3:0];
            side_select <= port_wdata[LATCH_SIDE_BIT];
            double_density_enable <= port_wdata[LATCH_DENSITY_BIT];
            double_density_enable_n <= ~port_wdata[LATCH_DENSITY_BIT];
            separator_divisor_sel0 <= ~port_wdata[LATCH_DENSITY_BIT];
        end else if (motor_end) begin
            drive_select <= 4'h0;
            side_select <= 1'b0;
            double_density_enable <= 1'b0;
            double_density_enable_n <= 1'b1;
            separator_divisor_sel0 <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            precomp_enable <= 1'b0;
        end else if (latch_write) begin
            precomp_enable <= port_wdata[LATCH_PRECOMP_BIT];
        end
    end

    // wait latch and its watchdog
    assign wait_watchdog_expiry = watchdog_count >= WATCHDOG_W'(WATCHDOG_LIMIT);
    assign wait_short_release = !wait_hold_req && watchdog_count == WATCHDOG_W'(SHORT_WAIT_COUNT);
    assign wait_release = core_irq || core_data_request || wait_short_release || wait_watchdog_expiry;

    // a new latch write wins over a release in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_held <= 1'b0;
            wait_hold_req <= 1'b0;
            cpu_wait_n <= 1'b1;
        end else if (latch_write) begin
            wait_held <= 1'b1;
            wait_hold_req <= port_wdata[LATCH_WAIT_BIT];
            cpu_wait_n <= 1'b0;
        end else if (wait_held && wait_release) begin
            wait_held <= 1'b0;
            cpu_wait_n <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_count <= '0;
        end else if (!wait_held || latch_write) begin
            watchdog_count <= '0;
        end else if (tick_1m && !wait_watchdog_expiry) begin
            watchdog_count <= watchdog_count + WATCHDOG_W'(1);
        end
    end

    // write precompensation path
    assign precomp_active = precomp_enable && double_density_enable;
    assign fifo_in_valid = pulse_pending && clk_2mhz && tick_4m;
    assign fifo_pop = fifo_out_valid && shift_reg == 3'h0 && tick_4m;
    assign fire = (tick_4m && shift_reg[0]) || (fifo_pop && !precomp_active);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_prev <= 1'b0;
            pulse_pending <= 1'b0;
        end else begin
            pulse_prev <= core_write_pulse;
            if (core_write_pulse && !pulse_prev) begin
                pulse_pending <= 1'b1;
            end else if (fifo_in_valid && write_pulse_ready) begin
                pulse_pending <= 1'b0;
            end
        end
    end

    // a stalled drain keeps up to three pulses, two queued and one pending, instead of dropping them
    pulse_fifo2 #(
        .WIDTH(2)
    ) pulse_buffer (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_ready(write_pulse_ready),
        .in_data({core_early, core_late}),
        .out_valid(fifo_out_valid),
        .out_ready(shift_reg == 3'h0 && tick_4m),
        .out_data(fifo_out_data)
    );

    // bit 0 early, bit 1 nominal, bit 2 late; one step per 4 MHz tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= 3'h0;
            precomp_parallel_load <= 1'b0;
        end else begin
            precomp_parallel_load <= fifo_pop && precomp_active;
            if (fifo_pop && precomp_active) begin
                shift_reg <= {fifo_out_data[0], ~|fifo_out_data, fifo_out_data[1]};
            end else if (tick_4m) begin
                shift_reg <= shift_reg >> 1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stretch_count <= 4'h0;
            write_data_out <= 1'b0;
        end else if (fire) begin
            stretch_count <= STRETCH_LOAD;
            write_data_out <= 1'b1;
        end else if (stretch_count != 4'h0) begin
            stretch_count <= stretch_count - 4'h1;
        end else begin
            write_data_out <= 1'b0;
        end
    end

    AST_MASK_CAPTURE: assert property (
        nmi_mask_write |=> nmi_mask == $past({port_wdata[7], port_wdata[6]}))
        else $error("nmi mask not captured");
    AST_STATUS_READ: assert property (
        status_read |=> port_rdata[7:6] == ~$past({core_irq, motor_timeout}))
        else $error("status bits wrong");
    AST_DRIVE_LATCH: assert property (
        latch_write |=> drive_select == $past(port_wdata[3:0]) && side_select == $past(port_wdata[4]))
        else $error("drive latch not loaded");
    AST_MOTOR_RESTART: assert property (
        latch_write |=> motor_on && motor_count == MOTOR_W'(MOTOR_CYCLES))
        else $error("motor pulse not restarted");
    AST_DESELECT: assert property (
        $fell(motor_on) |-> drive_select == 4'h0 && motor_timeout)
        else $error("drives still selected after motor off");
    AST_WAIT_SET: assert property (
        latch_write |=> !cpu_wait_n && wait_hold_req == $past(port_wdata[6]))
        else $error("wait not asserted");
    AST_IRQ_RELEASE: assert property (
        wait_held && !latch_write && (core_irq || core_data_request) |=> cpu_wait_n)
        else $error("wait not released");
    AST_WATCHDOG_BOUND: assert property (
        watchdog_count <= WATCHDOG_W'(WATCHDOG_LIMIT) && cpu_wait_n == !wait_held)
        else $error("watchdog passed its limit");
    AST_SHORT_WAIT: assert property (
        latch_write && !port_wdata[6] ##1 (!core_irq && !core_data_request && !io_write) [*3]
        |-> ##[1:40] cpu_wait_n)
        else $error("short wait too long");
    AST_CLOCK_PHASE: assert property (
        $changed(clk_1mhz) |-> $fell(clk_2mhz))
        else $error("1 MHz not lagging 2 MHz");
    AST_EARLY_STEP: assert property (
        fifo_pop && precomp_active && fifo_out_data == 2'b10 |-> ##5 fire)
        else $error("early pulse not one step");
    AST_LATE_STEP: assert property (
        fifo_pop && precomp_active && fifo_out_data == 2'b01 |-> ##10 !fire ##5 fire)
        else $error("late pulse not three steps");
    AST_BYPASS: assert property (
        fifo_pop && !precomp_active |=> write_data_out && shift_reg == 3'h0)
        else $error("bypass pulse delayed");
    AST_STRETCH: assert property (
        $rose(write_data_out) |-> write_data_out [*8])
        else $error("write pulse too short");
    AST_DIVISOR: assert property (
        separator_divisor_sel0 == !double_density_enable && !separator_divisor_sel1)
        else $error("separator divisor wrong");
    AST_NMI: assert property (
        (core_irq && nmi_mask[1]) |=> !cpu_nmi_n)
        else $error("nmi not raised");
    AST_XCVR: assert property (
        !disk_read_select_n |=> bus_drive_to_cpu)
        else $error("transceiver direction wrong");

    COV_WAIT_RELEASE: cover property (latch_write ##1 !cpu_wait_n ##[1:40] cpu_wait_n);
    COV_MOTOR_END: cover property (motor_end);
    COV_PRECOMP_FIRE: cover property (precomp_parallel_load ##[1:20] fire);
    COV_BUFFER_FULL: cover property (!write_pulse_ready);
endmodule

// ### rtl/pulse_fifo2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module pulse_fifo2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, low
    input wire logic in_valid, // entry offered
    output logic in_ready, // room for an entry
    input wire logic [WIDTH-1:0] in_data, // entry data
    output logic out_valid, // entry available
    input wire logic out_ready, // consumer takes entry
    output logic [WIDTH-1:0] out_data // oldest entry
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;
    logic push;
    logic pop;

    assign out_valid = count != 2'h0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 2'h0;
            in_ready <= 1'b1;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            count <= next_count;
            // ready is a flop so the source sees a clean full
            in_ready <= next_count != 2'h2;
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule

// ### shared/fdc_glue_pkg.sv
// constants for the floppy interface glue block
package fdc_glue_pkg;
    localparam logic [7:0] PORT_NMI = 8'he4;
    localparam logic [7:0] PORT_CORE_CMD = 8'hf0;
    localparam logic [7:0] PORT_CORE_TRACK = 8'hf1;
    localparam logic [7:0] PORT_CORE_SECTOR = 8'hf2;
    localparam logic [7:0] PORT_CORE_DATA = 8'hf3;
    localparam logic [7:0] PORT_DRIVE = 8'hf4;
    localparam logic [7:0] READ_UNMAPPED = 8'hff;
    localparam logic [4:0] STATUS_RESERVED = 5'h00;

    localparam int MASK_CORE_BIT = 7;
    localparam int MASK_MOTOR_BIT = 6;
    localparam int LATCH_SIDE_BIT = 4;
    localparam int LATCH_PRECOMP_BIT = 5;
    localparam int LATCH_WAIT_BIT = 6;
    localparam int LATCH_DENSITY_BIT = 7;

    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int FAST_HZ = 4_000_000;
    localparam int DIV_4M = CLK_HZ / FAST_HZ;

    localparam int PRECOMP_STEP_NS = 250;
    localparam int PRECOMP_STEP_CYCLES = PRECOMP_STEP_NS / CLK_PERIOD_NS;
    localparam int STRETCH_NS = 500;
    localparam int STRETCH_CYCLES = STRETCH_NS / CLK_PERIOD_NS;
    localparam int MOTOR_ON_MS = 3000;
    localparam int MOTOR_ON_CYCLES = MOTOR_ON_MS * (CLK_HZ / 1000);

    localparam int WATCHDOG_WIDTH = 12;
    localparam int WATCHDOG_LIMIT = 1024;
    localparam int SHORT_WAIT_COUNT = 2;
endpackage

// ### verif/fdc_glue_tb_top.sv
// self-checking bench for the floppy interface glue
`timescale 1ns/10ps
module fdc_glue_tb_top;
    import fdc_glue_pkg::*;
    typedef struct {logic [7:0] d; logic [7:0] e;} row_s;
    logic clk, arst_n, io_write, io_read, core_irq, core_data_request, core_write_pulse, core_early, core_late;
    logic disk_read_select_n, serial_read_select_n, core_write_strobe, core_read_strobe, write_pulse_ready;
    logic bus_drive_to_cpu, side_select, motor_on, dd, dd_n, cpu_wait_n, cpu_nmi_n, wdo, ppl, c2, c1, sref, sel0, sel1;
    logic [7:0] port_addr, port_wdata, port_rdata, core_rdata;
    logic [1:0] core_reg_index;
    logic [3:0] drive_select;
    logic [2:0] pv;
    int n_mismatch, samples_checked, cyc_cnt, i, n, k2, k1, kr, bad, d_b, d_e, d_n, d_l, d_x;
    // latch byte, then expected {sel0, dd_n, dd, side, drives}; one drive bit per write
    row_s rows[5] = '{'{8'h01, 8'hc1}, '{8'h12, 8'hd2}, '{8'h84, 8'h24}, '{8'h98, 8'h38}, '{8'ha1, 8'h21}};

    fdc_glue #(.MOTOR_CYCLES(200)) fdc_glue_inst (.clk(clk), .arst_n(arst_n), .io_write(io_write), .io_read(io_read),
        .port_addr(port_addr), .port_wdata(port_wdata), .port_rdata(port_rdata), .core_rdata(core_rdata),
        .core_write_strobe(core_write_strobe), .core_read_strobe(core_read_strobe), .core_reg_index(core_reg_index),
        .core_irq(core_irq), .core_data_request(core_data_request), .core_write_pulse(core_write_pulse),
        .core_early(core_early), .core_late(core_late), .write_pulse_ready(write_pulse_ready),
        .disk_read_select_n(disk_read_select_n), .serial_read_select_n(serial_read_select_n),
        .bus_drive_to_cpu(bus_drive_to_cpu), .drive_select(drive_select), .side_select(side_select),
        .motor_on(motor_on), .double_density_enable(dd), .double_density_enable_n(dd_n), .cpu_wait_n(cpu_wait_n),
        .cpu_nmi_n(cpu_nmi_n), .write_data_out(wdo), .precomp_parallel_load(ppl), .clk_2mhz(c2), .clk_1mhz(c1),
        .separator_reference_clock(sref), .separator_divisor_sel0(sel0), .separator_divisor_sel1(sel1));
    host_model host_model_inst (.clk(clk), .io_write(io_write), .io_read(io_read), .port_addr(port_addr),
        .port_wdata(port_wdata), .port_rdata(port_rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t expected %h got %h", $time, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.cyc(1'b0, a, 8'h00);
        tick(1);
        chk(e, port_rdata);
    endtask
    // cycles until the wait lets go, bounded so a stuck wait still ends
    task automatic wrel(output int k);
        k = 0;
        while (cpu_wait_n !== 1'b1 && k < 21000) begin
            tick(1);
            k++;
        end
    endtask
    // aligned to 2 MHz so every pulse meets the same tick phase
    task automatic pulse(input logic [7:0] v, input logic e, input logic l, output int d);
        int w;
        host_model_inst.cyc(1'b1, PORT_DRIVE, v);
        @(posedge c2);
        #1;
        core_early = e;
        core_late = l;
        core_write_pulse = 1'b1;
        tick(2);
        d = 2;
        w = 0;
        core_write_pulse = 1'b0;
        while (wdo !== 1'b1 && d < 100) begin
            tick(1);
            d++;
        end
        while (wdo === 1'b1 && w < 50) begin
            tick(1);
            w++;
        end
        chk(8'd10, 8'(w));
        tick(60);
    endtask

    initial begin
        {arst_n, core_irq, core_data_request, core_write_pulse, core_early, core_late} = 6'h00;
        {disk_read_select_n, serial_read_select_n} = 2'b11;
        core_rdata = 8'h00;
        tick(2);
        arst_n = 1'b1;
        chk(8'hff, port_rdata);
        chk(8'hd2, {cpu_wait_n, cpu_nmi_n, motor_on, sel0, sel1, wdo, write_pulse_ready, bus_drive_to_cpu});
        rd(PORT_NMI, 8'hc0);
        rd(PORT_NMI, 8'he0);
        rd(8'h00, READ_UNMAPPED);
        for (i = 0; i < 4; i++) begin
            core_rdata = 8'h5a + 8'(i);
            host_model_inst.cyc(1'b1, PORT_CORE_CMD + 8'(i), 8'h33);
            chk({5'h00, 1'b1, 2'(i)}, {5'h00, core_write_strobe, core_reg_index});
            host_model_inst.cyc(1'b0, PORT_CORE_CMD + 8'(i), 8'h00);
            chk({5'h00, 1'b1, 2'(i)}, {5'h00, core_read_strobe, core_reg_index});
            chk(8'h5a + 8'(i), port_rdata);
        end
        $display("test reset and ports done");
        foreach (rows[j]) begin
            host_model_inst.cyc(1'b1, PORT_DRIVE, rows[j].d);
            chk(8'h00, {7'h00, cpu_wait_n});
            chk(rows[j].e, {sel0, dd_n, dd, side_select, drive_select});
            chk(8'h01, {7'h00, motor_on});
            wrel(n);
            chk(8'h01, 8'(n >= 15 && n <= 45));
        end
        $display("test drive latch rows done");
        host_model_inst.cyc(1'b1, PORT_NMI, 8'h40);
        host_model_inst.cyc(1'b1, PORT_DRIVE, 8'h01);
        tick(150);
        host_model_inst.cyc(1'b1, PORT_DRIVE, 8'h01);
        tick(120);
        chk(8'h01, {7'h00, motor_on});
        tick(100);
        chk(8'h00, {3'h0, motor_on, drive_select});
        chk(8'h00, {7'h00, cpu_nmi_n});
        rd(PORT_NMI, 8'ha0);
        host_model_inst.cyc(1'b1, PORT_NMI, 8'h80);
        tick(2);
        chk(8'h01, {7'h00, cpu_nmi_n});
        core_irq = 1'b1;
        tick(3);
        chk(8'h00, {7'h00, cpu_nmi_n});
        rd(PORT_NMI, 8'h20);
        core_irq = 1'b0;
        $display("test motor and nmi done");
        for (i = 0; i < 4; i++) begin
            {disk_read_select_n, serial_read_select_n} = 2'(i);
            tick(2);
            chk(8'(i != 3), {7'h00, bus_drive_to_cpu});
        end
        {k2, k1, kr, bad} = '0;
        for (i = 0; i < 200; i++) begin
            pv = {c2, c1, sref};
            tick(1);
            k2 += int'(c2 && !pv[2]);
            k1 += int'(c1 && !pv[1]);
            kr += int'(sref && !pv[0]);
            bad += int'(c1 !== pv[1] && !(pv[2] && !c2));
        end
        chk(8'd20, 8'(k2));
        chk(8'd10, 8'(k1));
        chk(8'd40, 8'(kr));
        chk(8'd0, 8'(bad));
        pulse(8'h20, 1'b0, 1'b0, d_b);
        pulse(8'h80, 1'b0, 1'b0, d_x);
        pulse(8'ha0, 1'b1, 1'b0, d_e);
        pulse(8'ha0, 1'b0, 1'b0, d_n);
        pulse(8'ha0, 1'b0, 1'b1, d_l);
        chk(8'(d_b), 8'(d_x));
        chk(8'd5, 8'(d_e - d_b));
        chk(8'd10, 8'(d_n - d_b));
        chk(8'd15, 8'(d_l - d_b));
        // late pulses one 2 MHz period apart drain slower than they come; none may be lost
        host_model_inst.cyc(1'b1, PORT_DRIVE, 8'ha0);
        {k1, kr, bad} = '0;
        for (i = 0; i < 120; i++) begin
            core_write_pulse = i < 40 && i % 10 < 2;
            pv[0] = wdo;
            tick(1);
            k1 += int'(wdo && !pv[0]);
            kr += int'(!write_pulse_ready);
            bad += int'(ppl);
        end
        chk(8'd4, 8'(k1));
        chk(8'd4, 8'(bad));
        chk(8'h01, 8'(kr > 0));
        $display("test clocks and precomp done");
        for (i = 0; i < 3; i++) begin
            host_model_inst.cyc(1'b1, PORT_DRIVE, 8'h41);
            chk(8'h00, {7'h00, cpu_wait_n});
            tick(5);
            core_irq = (i == 0);
            core_data_request = (i == 1);
            wrel(n);
            core_irq = 1'b0;
            core_data_request = 1'b0;
            if (i < 2) begin
                chk(8'h01, 8'(n <= 3));
            end else begin
                chk(8'h01, 8'(n >= 20400 && n <= 20540));
            end
        end
        $display("test wait release done");
        // reset in mid-wait lets the processor go and shows in status again
        host_model_inst.cyc(1'b1, PORT_DRIVE, 8'h41);
        tick(3);
        arst_n = 1'b0;
        tick(2);
        chk(8'h10, {3'h0, cpu_wait_n, drive_select});
        arst_n = 1'b1;
        rd(PORT_NMI, 8'hc0);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule

// ### verif/host_model.sv
// host processor model issuing single port reads and writes
`timescale 1ns/10ps
module host_model (
    input wire logic clk, // system clock
    output logic io_write, // port write strobe
    output logic io_read, // port read strobe
    output logic [7:0] port_addr, // port address
    output logic [7:0] port_wdata, // port write data
    input wire logic [7:0] port_rdata // read answer, sampled by the bench
);
    initial begin
        io_write = 1'b0;
        io_read = 1'b0;
        port_addr = 8'h00;
        port_wdata = 8'h00;
    end
    // released lines show the inverse, so a stale address or byte never passes as held
    task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_write = wr;
        io_read = !wr;
        port_addr = a;
        port_wdata = d;
        @(posedge clk);
        #1;
        io_write = 1'b0;
        io_read = 1'b0;
        port_addr = ~a;
        port_wdata = ~d;
    endtask
endmodule
